// ==== rtl/dac_serial_register_map.sv ====
// serial port decoder and register bank of the converter
//
// Functional notes
// [R1] gated clock: host sends exact burst
// [R2] read frame, then nop shifts data
// [R3] output pin enabled at the read-frame strobe
// [R4] pin released at strobe after readback
// [R5] host reads code via 020001, 000000
// [R6] read frame: low two bits address
// [R7] read address 00 flags 01 code 10 config
// [R8] power-on clears every register
// [R9] address 01 writes output code
// [R10] code keeps bits 15 to 4
// [R11] address 55 writes configuration
// [R12] configuration field layout
// [R13] outputs need output_on, span selects which
// [R14] span_extend widens voltage span
// [R15] resistor bit drives select signal
// [R16] slew stepping and chain forwarding bits
// [R17] span code decode to output kind
// [R18] address 56 bit 0 restarts code and config
// [R19] flags read-only, bits 5 4 3
// [R20] slewing while enabled and off target
// [R21] fault and thermal flags follow inputs
// [R22] 24 bits msb first, strobe latches
// [R23] exactly 24 edges before strobe
// [R24] address zero is nop
// [R25] chain bits change on falling edge
// [R26] unknown address, span 100 do nothing
// [R27] restart bit clears itself
`timescale 1ns/1ps
`include "dac_serial_params.svh"
module dac_serial_register_map (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        sclk,
  input  wire logic        latch,
  input  wire logic        serial_in_pin,
  input  wire logic        current_fault_in,
  input  wire logic        over_temp_in,
  output logic             serial_out_pin,
  output logic             serial_out_oe_b,
  output logic [11:0]      dac_code,
  output logic             voltage_out_on,
  output logic             current_out_on,
  output logic [2:0]       output_span_code,
  output logic             span_extend,
  output logic             external_resistor_select,
  output logic             clear_level_select
);
  // pin synchronisers: first stage read only by second
  logic [1:0] sclk_sync;
  logic [1:0] latch_sync;
  logic [1:0] serial_in_pin_sync;
  logic [1:0] fault_sync;
  logic [1:0] temp_sync;
  logic       sclk_prev;
  logic       latch_prev;

  logic [23:0] shift_in;
  logic [15:0] output_code;
  logic [15:0] output_config;
  logic [15:0] readback_word;
  logic [11:0] slew_target;
  logic [11:0] slew_pos;
  logic        restart;
  logic        read_pending;
  dac_serial_pkg::sdo_state_t sdo_state;
  dac_serial_pkg::sdo_state_t next_sdo_state;
  logic [7:0]  base_cnt;
  logic [7:0]  rate_cnt;

  wire sclk_rise  = sclk_sync[1] & ~sclk_prev;
  wire sclk_fall  = ~sclk_sync[1] & sclk_prev;
  wire latch_rise = latch_sync[1] & ~latch_prev;
  // latched frame fields; strobe takes the last 24 bits shifted
  wire [7:0]  frame_addr = shift_in[23:16]; // R22
  wire [15:0] frame_data = shift_in[15:0];
  wire        wr_code    = latch_rise & (frame_addr == `ADDR_CODE); // R9
  wire        wr_config  = latch_rise & (frame_addr == `ADDR_CONFIG); // R11
  wire        wr_restart = latch_rise & (frame_addr == `ADDR_RESTART)
                           & frame_data[0]; // R18
  wire        rd_request = latch_rise & (frame_addr == `ADDR_READBACK); // R2
  // nop and unassigned addresses fall through all strobes above
  wire        frame_nop  = frame_addr == `ADDR_NOP; // R24 R26

  // config field views
  wire        cfg_out_on   = output_config[`CFG_OUT_ON];
  wire [2:0]  cfg_span     = output_config[`CFG_SPAN_HI:0];
  wire        cfg_slew_on  = output_config[`CFG_SLEW_ON]; // R16
  wire        cfg_chain_on = output_config[`CFG_CHAIN_ON]; // R16
  wire [3:0]  cfg_rate     = output_config[`CFG_RATE_HI:`CFG_RATE_LO];
  wire [2:0]  cfg_inc      = output_config[`CFG_INC_HI:`CFG_INC_LO];
  // span decode: 0xx voltage, 101..111 current, 100 neither
  wire        span_is_volt = ~cfg_span[2]; // R17
  wire        span_is_curr = cfg_span[2] & (cfg_span != `SPAN_ILLEGAL); // R26
  wire        slewing      = cfg_slew_on & (slew_pos != slew_target); // R20

  wire [15:0] flags_word;
  assign flags_word = {10'h000, fault_sync[1], slewing, temp_sync[1],
                       3'h0}; // R19 R21

  // readback selection by two-bit address, frame bits 15..2 ignored
  wire [15:0] rd_select =
    (frame_data[1:0] == `RD_FLAGS)  ? flags_word :
    (frame_data[1:0] == `RD_CODE)   ? output_code :
    (frame_data[1:0] == `RD_CONFIG) ? output_config :
    `RESET_WORD; // R6 R7

  // step size: 1 << code, saturating at the target
  function automatic logic [11:0] step_toward(
    input logic [11:0] pos,
    input logic [11:0] tgt,
    input logic [2:0]  inc
  );
    logic [12:0] sz;
    sz = 13'h0001 << inc;
    if (tgt > pos) begin
      step_toward = ({1'b0, tgt - pos} > sz) ? pos + sz[11:0] : tgt;
    end else begin
      step_toward = ({1'b0, pos - tgt} > sz) ? pos - sz[11:0] : tgt;
    end
  endfunction : step_toward

  // synchronisers and edge history
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync  <= 2'h0;
      latch_sync <= 2'h0;
      serial_in_pin_sync  <= 2'h0;
      fault_sync <= 2'h0;
      temp_sync  <= 2'h0;
      sclk_prev  <= 1'b0;
      latch_prev <= 1'b0;
    end else begin
      sclk_sync  <= {sclk_sync[0], sclk};
      latch_sync <= {latch_sync[0], latch};
      serial_in_pin_sync  <= {serial_in_pin_sync[0], serial_in_pin};
      fault_sync <= {fault_sync[0], current_fault_in};
      temp_sync  <= {temp_sync[0], over_temp_in};
      sclk_prev  <= sclk_sync[1];
      latch_prev <= latch_sync[1];
    end
  end

  // input shifter keeps running regardless of strobe; no edge count,
  // so a wrong-length frame simply latches the wrong bits
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_in <= 24'h000000;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[22:0], serial_in_pin_sync[1]}; // R22 R23 R1
    end
  end

  // register writes; restart returns code and config to power-on state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      output_code   <= `RESET_WORD; // R8
      output_config <= `RESET_WORD; // R8
      restart       <= 1'b0;
    end else if (restart) begin
      output_code   <= `RESET_WORD;
      output_config <= `RESET_WORD;
      restart       <= 1'b0; // R27
    end else begin
      restart <= wr_restart; // R18
      if (wr_code) begin
        output_code <= {frame_data[`CODE_HI:`CODE_LO], 4'h0}; // R10
      end
      if (wr_config) begin
        output_config <= frame_data; // R12
      end
    end
  end

  // readback pin state: armed by read frame, driven from the next cycle
  always_comb begin
    next_sdo_state = sdo_state;
    case (sdo_state)
      dac_serial_pkg::sdo_off:
        if (rd_request) next_sdo_state = dac_serial_pkg::sdo_armed;
      dac_serial_pkg::sdo_armed:
        next_sdo_state = dac_serial_pkg::sdo_active; // enter active on the next cycle
      dac_serial_pkg::sdo_active:
        if (latch_rise && !rd_request)
          next_sdo_state = dac_serial_pkg::sdo_off; // R4
      default:
        next_sdo_state = dac_serial_pkg::sdo_off;
    endcase
  end

  // pin enable rises one cycle after the read-frame strobe; the
  // strobe itself ends the request frame, so this is that edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_state       <= dac_serial_pkg::sdo_off;
      read_pending    <= 1'b0;
      readback_word   <= `RESET_WORD;
      serial_out_oe_b <= 1'b1; // R3
    end else begin
      sdo_state <= next_sdo_state;
      read_pending <= rd_request;
      // the word is consumed msb first, one bit per falling sclk
      if (rd_request) begin
        readback_word <= rd_select; // R7
      end else if (sclk_fall && (sdo_state == dac_serial_pkg::sdo_active)) begin
        readback_word <= {readback_word[14:0], 1'b0}; // R2
      end
      serial_out_oe_b <= ~((next_sdo_state == dac_serial_pkg::sdo_active)
                           | (next_sdo_state == dac_serial_pkg::sdo_armed)
                           | cfg_chain_on); // R3 R4
    end
  end

  // serial output takes the readback msb two cycles after the read strobe, then changes on
  // falling sclk: next readback bit, or in chain mode the bit leaving the shifter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out_pin <= 1'b0;
    end else if (read_pending) begin
      serial_out_pin <= readback_word[15];
    end else if (sclk_fall) begin
      serial_out_pin <= (sdo_state == dac_serial_pkg::sdo_active)
                        ? readback_word[14] : shift_in[23]; // R25 R16 R2
    end
  end

  // slew tick divider: base tick then rate code
  wire base_tick = base_cnt == (`SLEW_BASE_DIV - 8'h01);
  wire [7:0] rate_div = {4'h0, cfg_rate} + 8'h01;
  wire slew_tick = base_tick & (rate_cnt >= rate_div);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      base_cnt <= 8'h00;
      rate_cnt <= 8'h00;
    end else begin
      base_cnt <= base_tick ? 8'h00 : base_cnt + 8'h01;
      if (slew_tick) rate_cnt <= 8'h00;
      else if (base_tick) rate_cnt <= rate_cnt + 8'h01;
    end
  end

  // output code walks toward target when slewing is on
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      slew_target <= `RESET_CODE;
      slew_pos    <= `RESET_CODE;
    end else begin
      slew_target <= output_code[`CODE_HI:`CODE_LO];
      if (!cfg_slew_on) slew_pos <= slew_target;
      else if (slew_tick)
        slew_pos <= step_toward(slew_pos, slew_target, cfg_inc); // R16
    end
  end

  // analog-facing controls, all registered
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dac_code                 <= `RESET_CODE;
      voltage_out_on           <= 1'b0; // R8
      current_out_on           <= 1'b0;
      output_span_code         <= 3'h0;
      span_extend              <= 1'b0;
      external_resistor_select <= 1'b0;
      clear_level_select       <= 1'b0;
    end else begin
      dac_code                 <= slew_pos;
      voltage_out_on           <= cfg_out_on & span_is_volt; // R13
      current_out_on           <= cfg_out_on & span_is_curr; // R13 R26
      output_span_code         <= cfg_span; // R17
      span_extend              <= output_config[`CFG_SPAN_EXT]; // R14
      external_resistor_select <= output_config[`CFG_EXTERNAL_RESISTOR_SELECT]; // R15
      clear_level_select       <= output_config[`CFG_CLEAR_LEVEL_SELECT];
    end
  end
endmodule : dac_serial_register_map

// ==== rtl/dac_serial_params.svh ====
// constants for the serial converter register bank
`ifndef DAC_SERIAL_PARAMS_SVH
`define DAC_SERIAL_PARAMS_SVH
`define FRAME_BITS      24
`define ADDR_NOP        8'h00
`define ADDR_CODE       8'h01
`define ADDR_READBACK   8'h02
`define ADDR_CONFIG     8'h55
`define ADDR_RESTART    8'h56
`define RD_FLAGS        2'h0
`define RD_CODE         2'h1
`define RD_CONFIG       2'h2
`define CFG_CLEAR_LEVEL_SELECT      15
`define CFG_SPAN_EXT    14
`define CFG_EXTERNAL_RESISTOR_SELECT        13
`define CFG_OUT_ON      12
`define CFG_RATE_HI     11
`define CFG_RATE_LO     8
`define CFG_INC_HI      7
`define CFG_INC_LO      5
`define CFG_SLEW_ON     4
`define CFG_CHAIN_ON    3
`define CFG_SPAN_HI     2
`define FLG_IFAULT      5
`define FLG_SLEWING     4
`define FLG_OVERTEMP    3
`define SPAN_ILLEGAL    3'h4
`define CODE_HI         15
`define CODE_LO         4
`define RESET_CODE      12'h000
`define RESET_WORD      16'h0000
// base slew tick: 100 MHz / 10 = 10 MHz, then divided per rate code
`define SLEW_BASE_DIV   8'h0a
`endif

// ==== rtl/dac_serial_pkg.sv ====
// types for the serial converter register bank
package dac_serial_pkg;
  typedef enum logic [2:0] {
    sdo_off    = 3'b001,
    sdo_armed  = 3'b010,
    sdo_active = 3'b100
  } sdo_state_t;
endpackage : dac_serial_pkg

// ==== tb/dac_serial_monitor.sv ====
// assertion checker bound to the serial register bank
`timescale 1ns/1ps
module dac_serial_monitor (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       latch,
  input wire logic       serial_out_oe_b,
  input wire logic       voltage_out_on,
  input wire logic       current_out_on,
  input wire logic [2:0] output_span_code,
  input wire logic       span_extend,
  input wire logic       external_resistor_select,
  input wire logic       clear_level_select
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // which output is live follows the span code
  a_outs_exclusive: assert property (
    !(voltage_out_on && current_out_on)) else $error("both outputs on");
  a_volt_span: assert property (
    voltage_out_on |-> !output_span_code[2]) else $error("voltage span");
  a_cur_span: assert property (
    current_out_on |-> output_span_code[2] && output_span_code != 3'h4)
    else $error("current span");
  // host holds the strobe 12 cycles, so updates land inside it
  a_span_on_latch: assert property (
    $changed(output_span_code) |-> latch) else $error("span moved");
  a_bits_on_latch: assert property (
    $changed({span_extend, external_resistor_select, clear_level_select})
    |-> latch) else $error("config bits moved");
  a_outs_on_latch: assert property (
    $rose(voltage_out_on) || $rose(current_out_on) |-> latch)
    else $error("output on without strobe");
  // readback pin enable and release at the strobe
  a_pin_on_latch: assert property (
    $fell(serial_out_oe_b) |-> latch ##1 !serial_out_oe_b [*8])
    else $error("pin enable");
  a_pin_off_latch: assert property (
    $rose(serial_out_oe_b) |-> latch) else $error("pin release");
  c_read: cover property ($fell(serial_out_oe_b));
  c_volt: cover property ($rose(voltage_out_on));
  c_cur: cover property ($rose(current_out_on));
endmodule : dac_serial_monitor
bind dac_serial_register_map dac_serial_monitor i_mon (
  .mclk(mclk), .rst_b(rst_b), .latch(latch),
  .serial_out_oe_b(serial_out_oe_b), .voltage_out_on(voltage_out_on),
  .current_out_on(current_out_on), .output_span_code(output_span_code),
  .span_extend(span_extend), .clear_level_select(clear_level_select),
  .external_resistor_select(external_resistor_select));

// ==== tb/serial_host.sv ====
// host model: shifts frames in and samples the readback pin
`timescale 1ns/1ps
module serial_host (
  input  wire logic        mclk,
  input  wire logic        serial_out_pin,
  output logic             sclk,
  output logic             latch,
  output logic             serial_in_pin,
  output logic [23:0]      rx
);
  initial begin
    sclk = 1'b0;
    latch = 1'b0;
    serial_in_pin = 1'b0;
    rx = 24'h000000;
  end
  // gated 80 ns clock, exactly 24 rises, then the strobe
  task automatic send(input logic [23:0] f);
    for (int i = 23; i >= 0; i--) begin
      @(negedge mclk);
      sclk = 1'b0;
      serial_in_pin = f[i];
      repeat (4) @(negedge mclk);
      sclk = 1'b1;
      rx = {rx[22:0], serial_out_pin};
      repeat (3) @(negedge mclk);
    end
    @(negedge mclk);
    sclk = 1'b0;
    serial_in_pin = ~f[0]; // line not held past the frame
    repeat (4) @(negedge mclk);
    latch = 1'b1;
    repeat (12) @(negedge mclk);
    latch = 1'b0;
    repeat (4) @(negedge mclk);
  endtask : send
endmodule : serial_host

// ==== tb/tb.sv ====
// self-checking bench for the serial register bank
`timescale 1ns/1ps
module tb;
  logic        mclk, rst_b, fault, hot, sclk, latch, sin, sout, oe_b;
  logic        von, ion, sext, rsel, clsel;
  logic [11:0] code;
  logic [2:0]  span;
  logic [23:0] rx;
  int          err_count, checks, m_code, m_cfg;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  dac_serial_register_map i_dac_serial_register_map (
    .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .latch(latch),
    .serial_in_pin(sin), .current_fault_in(fault), .over_temp_in(hot),
    .serial_out_pin(sout), .serial_out_oe_b(oe_b), .dac_code(code),
    .voltage_out_on(von), .current_out_on(ion), .output_span_code(span),
    .span_extend(sext), .external_resistor_select(rsel),
    .clear_level_select(clsel));
  serial_host i_serial_host (.mclk(mclk), .serial_out_pin(sout),
    .sclk(sclk), .latch(latch), .serial_in_pin(sin), .rx(rx));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // compare code, span, config bits and output enables with the model registers
  task automatic outs;
    logic [2:0] s;
    s = m_cfg[2:0];
    check(16'(code), 16'(m_code[15:4]));
    check(16'(span), 16'(s));
    check(16'({sext, rsel, clsel}), 16'({m_cfg[14], m_cfg[13], m_cfg[15]}));
    check(16'({von, ion}), 16'({m_cfg[12] && !s[2], m_cfg[12] && s[2] && s != 3'h4}));
  endtask : outs
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    if (a == 8'h01) m_code = d;
    if (a == 8'h55) m_cfg = d;
    if (a == 8'h56 && d[0]) begin
      m_code = 0;
      m_cfg = 0;
    end
    i_serial_host.send({a, d});
    outs();
  endtask : wr
  // read request with random ignored bits, then the no-op frame
  task automatic rd(input logic [1:0] ra, input logic [15:0] ew);
    i_serial_host.send({8'h02, 14'($urandom), ra});
    check(16'(oe_b), 16'h0000);
    check(16'(sout), 16'(ew[15]));
    i_serial_host.send(24'h000000);
    check(rx[23:8], ew);
    check(16'(oe_b), 16'h0001);
  endtask : rd
  task automatic conclude;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    rst_b = 1'b0;
    fault = 1'b0;
    hot = 1'b0;
    m_code = 0;
    m_cfg = 0;
    void'($urandom(32'h6202));
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    outs();
    check(16'(oe_b), 16'h0001);
    repeat (6) begin
      wr(8'h01, 16'($urandom));
      rd(2'h1, 16'(m_code) & 16'hfff0);
    end
    for (int s = 0; s < 16; s++) begin
      fault = 1'($urandom);
      hot = 1'($urandom);
      wr(8'h55, 16'($urandom) & 16'hefe0 | {13'h0, 3'(s)} | {3'h0, s[3], 12'h0});
      rd(2'h2, 16'(m_cfg));
    end
    rd(2'h0, {10'h000, fault, 1'b0, hot, 3'h0});
    wr(8'h33, 16'($urandom));
    wr(8'h00, 16'($urandom));
    wr(8'h56, 16'hfffe);
    wr(8'h56, 16'h0001);
    wr(8'h01, 16'habc0);
    conclude();
  end
  // watchdog against a hung sequence
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    conclude();
  end
endmodule : tb
